// file: src/tsa_pkg.sv
// Shared constants and types for the tag state / anticollision link.
// Assumes both ends run on one clock, mclk, with a synchronous reset.
package tsa_pkg;
	localparam int HANDLE_W = 8;
	localparam int SLOT_W = 4;
	localparam int SLOT_COUNT = 16;
	localparam logic [3:0] LAST_SLOT = 4'hF;
	localparam logic [7:0] LFSR_SEED = 8'hA5;
	localparam logic [7:0] LFSR_TAPS = 8'hB8;

	typedef enum logic [2:0] {
		TSA_CMD_INV_OPEN,
		TSA_CMD_SLOT_START,
		TSA_CMD_SLOT_MARK,
		TSA_CMD_CHOOSE,
		TSA_CMD_RETIRE,
		TSA_CMD_FETCH,
		TSA_CMD_STORE,
		TSA_CMD_SERIAL
	} tsa_cmd_t;

	typedef enum logic [2:0] {
		TSA_ST_OFF,
		TSA_ST_READY,
		TSA_ST_INVENTORY,
		TSA_ST_SELECTED,
		TSA_ST_DESELECTED,
		TSA_ST_DEACTIVATED
	} tsa_state_t;
endpackage : tsa_pkg

// file: src/tsa_link_if.sv
// Link between the reader end and the tag end: one command strobe, one reply strobe.
// Assumes the testbench supplies mclk and rst and models field power.
`timescale 1ns/1ps
interface tsa_link_if (
	input wire logic mclk,
	input wire logic rst
);
	logic cmd_valid;
	tsa_pkg::tsa_cmd_t cmd_code;
	logic [7:0] cmd_arg;
	logic cmd_frame_ok;
	logic rsp_valid;
	logic [7:0] rsp_handle;
	logic exec_valid;
	tsa_pkg::tsa_cmd_t exec_code;

	modport tag (
		input mclk, rst, cmd_valid, cmd_code, cmd_arg, cmd_frame_ok,
		output rsp_valid, rsp_handle, exec_valid, exec_code
	);
	modport reader (
		input mclk, rst, rsp_valid, rsp_handle,
		output cmd_valid, cmd_code, cmd_arg, cmd_frame_ok
	);
endinterface : tsa_link_if

// file: src/tsa_tag.sv
// Tag end: operating state, random tag handle and slot answers.
// Assumes commands arrive already decoded; field_ok is synchronous to mclk.
`timescale 1ns/1ps
module tsa_tag (
	tsa_link_if.tag link,
	input wire logic field_ok,
	output tsa_pkg::tsa_state_t state,
	output logic [7:0] handle
);
	tsa_pkg::tsa_state_t state_q;
	logic [7:0] handle_q;
	logic [7:0] lfsr_q;
	logic rsp_valid_q;
	logic [7:0] rsp_handle_q;
	logic exec_valid_q;
	tsa_pkg::tsa_cmd_t exec_code_q;
	logic take;
	logic match;
	logic [7:0] fresh;

	// Free-running LFSR: the entropy comes from when commands arrive
	always_ff @(posedge link.mclk) begin
		if (link.rst) begin
			lfsr_q <= tsa_pkg::LFSR_SEED;
		end else begin
			lfsr_q <= {1'b0, lfsr_q[7:1]} ^ (lfsr_q[0] ? tsa_pkg::LFSR_TAPS : 8'h00);
		end
	end

	assign fresh = lfsr_q;
	assign take = link.cmd_valid && link.cmd_frame_ok;
	assign match = link.cmd_arg == handle_q;

	// One flag per accepted command; a bad frame raises none of them
	logic hit_open;
	logic hit_start;
	logic hit_mark;
	logic hit_choose;
	logic hit_retire;
	logic hit_fetch;
	logic hit_store;
	logic hit_serial;
	logic in_ready;
	logic in_inv;
	logic in_sel;

	always_comb begin
		hit_open = 1'b0;
		hit_start = 1'b0;
		hit_mark = 1'b0;
		hit_choose = 1'b0;
		hit_retire = 1'b0;
		hit_fetch = 1'b0;
		hit_store = 1'b0;
		hit_serial = 1'b0;
		if (take) begin
			unique case (link.cmd_code)
				tsa_pkg::TSA_CMD_INV_OPEN: hit_open = 1'b1;
				tsa_pkg::TSA_CMD_SLOT_START: hit_start = 1'b1;
				tsa_pkg::TSA_CMD_SLOT_MARK: hit_mark = 1'b1;
				tsa_pkg::TSA_CMD_CHOOSE: hit_choose = 1'b1;
				tsa_pkg::TSA_CMD_RETIRE: hit_retire = 1'b1;
				tsa_pkg::TSA_CMD_FETCH: hit_fetch = 1'b1;
				tsa_pkg::TSA_CMD_STORE: hit_store = 1'b1;
				tsa_pkg::TSA_CMD_SERIAL: hit_serial = 1'b1;
			endcase
		end
	end

	// State qualifiers drop with the field so nothing moves while power fails
	assign in_ready = state_q == tsa_pkg::TSA_ST_READY && field_ok;
	assign in_inv = state_q == tsa_pkg::TSA_ST_INVENTORY && field_ok;
	assign in_sel = state_q == tsa_pkg::TSA_ST_SELECTED && field_ok;

	always_ff @(posedge link.mclk) begin
		if (link.rst || !field_ok) begin
			state_q <= tsa_pkg::TSA_ST_OFF;
		end else begin
			unique case (state_q)
				tsa_pkg::TSA_ST_OFF: state_q <= tsa_pkg::TSA_ST_READY;
				tsa_pkg::TSA_ST_READY: begin
					if (take && link.cmd_code == tsa_pkg::TSA_CMD_INV_OPEN) begin
						state_q <= tsa_pkg::TSA_ST_INVENTORY;
					end
				end
				tsa_pkg::TSA_ST_INVENTORY: begin
					if (take && link.cmd_code == tsa_pkg::TSA_CMD_CHOOSE && match) begin
						state_q <= tsa_pkg::TSA_ST_SELECTED;
					end
				end
				tsa_pkg::TSA_ST_SELECTED: begin
					if (take && link.cmd_code == tsa_pkg::TSA_CMD_CHOOSE && !match) begin
						state_q <= tsa_pkg::TSA_ST_DESELECTED;
					end else if (take && link.cmd_code == tsa_pkg::TSA_CMD_RETIRE) begin
						state_q <= tsa_pkg::TSA_ST_DEACTIVATED;
					end
				end
				tsa_pkg::TSA_ST_DESELECTED: begin
					if (take && link.cmd_code == tsa_pkg::TSA_CMD_CHOOSE && match) begin
						state_q <= tsa_pkg::TSA_ST_SELECTED;
					end
				end
				// Retire and choose flags are ignored here until power is lost
				tsa_pkg::TSA_ST_DEACTIVATED: state_q <= tsa_pkg::TSA_ST_DEACTIVATED;
				default: state_q <= tsa_pkg::TSA_ST_OFF;
			endcase
		end
	end

	// Handle: only Ready entry, inventory-open and slot start touch it
	always_ff @(posedge link.mclk) begin
		if (link.rst) begin
			handle_q <= 8'h00;
		end else if (state_q == tsa_pkg::TSA_ST_OFF && field_ok) begin
			handle_q <= fresh;
		end else if (hit_open && (in_ready || in_inv)) begin
			// Reply carries this same value, so a later choose-tag can match
			handle_q <= fresh;
		end else if (hit_start && in_inv) begin
			handle_q <= {handle_q[7:4], fresh[3:0]};
		end
	end

	// Reply strobe; every other case stays silent
	always_ff @(posedge link.mclk) begin
		if (link.rst || !field_ok) begin
			rsp_valid_q <= 1'b0;
		end else if (hit_open && (in_ready || in_inv)) begin
			rsp_valid_q <= 1'b1;
		end else if (hit_start && in_inv) begin
			rsp_valid_q <= fresh[3:0] == 4'h0;
		end else if (hit_mark && in_inv) begin
			rsp_valid_q <= link.cmd_arg[3:0] == handle_q[3:0];
		end else begin
			rsp_valid_q <= 1'b0;
		end
	end

	// Reply value; also loaded on silent slot commands, since the reader reads it only with the strobe
	always_ff @(posedge link.mclk) begin
		if (link.rst || !field_ok) begin
			rsp_handle_q <= 8'h00;
		end else if (hit_open && (in_ready || in_inv)) begin
			rsp_handle_q <= fresh;
		end else if (hit_start && in_inv) begin
			rsp_handle_q <= {handle_q[7:4], fresh[3:0]};
		end else if (hit_mark && in_inv) begin
			rsp_handle_q <= handle_q;
		end
	end

	// Access commands are passed on only when selected
	always_ff @(posedge link.mclk) begin
		if (link.rst || !field_ok) begin
			exec_valid_q <= 1'b0;
			exec_code_q <= tsa_pkg::TSA_CMD_FETCH;
		end else begin
			exec_valid_q <= in_sel && (hit_fetch || hit_store || hit_serial);
			exec_code_q <= link.cmd_code;
		end
	end

	assign link.rsp_valid = rsp_valid_q;
	assign link.rsp_handle = rsp_handle_q;
	assign link.exec_valid = exec_valid_q;
	assign link.exec_code = exec_code_q;
	assign state = state_q;
	assign handle = handle_q;
endmodule : tsa_tag

// file: src/tsa_reader.sv
// Reader end: runs inventory-open, slot rounds, choose, access, release.
// Assumes a single tag reply arrives one cycle after the command; collision is an input.
`timescale 1ns/1ps
module tsa_reader #(
	parameter int MAX_TAGS = 16
) (
	tsa_link_if.reader link,
	input wire logic start,
	input wire logic collision,
	input wire logic retire_mode,
	output logic busy,
	output logic found_valid,
	output logic [7:0] found_handle
);
	typedef enum logic [3:0] {
		RD_IDLE, RD_OPEN, RD_OPEN_WAIT, RD_SLOT, RD_SLOT_WAIT, RD_CHOOSE,
		RD_ACCESS, RD_RELEASE, RD_NEXT
	} tsa_rd_state_t;

	tsa_rd_state_t st_q;
	logic [3:0] slot_q;
	logic coll_q;
	logic from_open_q;
	logic [7:0] store_q [MAX_TAGS];
	logic [4:0] cnt_q;
	logic [4:0] idx_q;
	logic cmd_valid_q;
	tsa_pkg::tsa_cmd_t cmd_code_q;
	logic [7:0] cmd_arg_q;
	logic busy_q;
	logic found_valid_q;
	logic [7:0] found_q;

	always_ff @(posedge link.mclk) begin
		if (link.rst) begin
			st_q <= RD_IDLE;
			slot_q <= 4'h0;
			coll_q <= 1'b0;
			from_open_q <= 1'b0;
			cnt_q <= 5'h00;
			idx_q <= 5'h00;
			cmd_valid_q <= 1'b0;
			cmd_code_q <= tsa_pkg::TSA_CMD_INV_OPEN;
			cmd_arg_q <= 8'h00;
			busy_q <= 1'b0;
			found_valid_q <= 1'b0;
			found_q <= 8'h00;
		end else begin
			cmd_valid_q <= 1'b0;
			found_valid_q <= 1'b0;
			unique case (st_q)
				RD_IDLE: if (start) begin
					st_q <= RD_OPEN;
					busy_q <= 1'b1;
				end
				RD_OPEN: begin
					cmd_valid_q <= 1'b1;
					cmd_code_q <= tsa_pkg::TSA_CMD_INV_OPEN;
					st_q <= RD_OPEN_WAIT;
				end
				RD_OPEN_WAIT: if (!cmd_valid_q) begin
					if (collision) begin
						slot_q <= 4'h0;
						coll_q <= 1'b0;
						cnt_q <= 5'h00;
						st_q <= RD_SLOT;
					end else if (link.rsp_valid) begin
						from_open_q <= 1'b1;
						found_q <= link.rsp_handle;
						cmd_arg_q <= link.rsp_handle;
						st_q <= RD_CHOOSE;
					end else begin
						st_q <= RD_OPEN;
					end
				end
				RD_SLOT: begin
					cmd_valid_q <= 1'b1;
					cmd_code_q <= slot_q == 4'h0 ? tsa_pkg::TSA_CMD_SLOT_START
						: tsa_pkg::TSA_CMD_SLOT_MARK;
					cmd_arg_q <= {4'h0, slot_q};
					st_q <= RD_SLOT_WAIT;
				end
				RD_SLOT_WAIT: if (!cmd_valid_q) begin
					if (collision) begin
						coll_q <= 1'b1;
					end else if (link.rsp_valid && cnt_q < 5'(MAX_TAGS)) begin
						store_q[cnt_q[3:0]] <= link.rsp_handle;
						cnt_q <= cnt_q + 5'h01;
						found_valid_q <= 1'b1;
						found_q <= link.rsp_handle;
					end
					if (slot_q == tsa_pkg::LAST_SLOT) begin
						idx_q <= 5'h00;
						from_open_q <= 1'b0;
						st_q <= RD_NEXT;
					end else begin
						slot_q <= slot_q + 4'h1;
						st_q <= RD_SLOT;
					end
				end
				RD_NEXT: begin
					if (idx_q < cnt_q) begin
						cmd_arg_q <= store_q[idx_q[3:0]];
						st_q <= RD_CHOOSE;
					end else begin
						st_q <= coll_q ? RD_SLOT : RD_OPEN;
						slot_q <= 4'h0;
						coll_q <= 1'b0;
						cnt_q <= 5'h00;
					end
				end
				RD_CHOOSE: begin
					cmd_valid_q <= 1'b1;
					cmd_code_q <= tsa_pkg::TSA_CMD_CHOOSE;
					st_q <= RD_ACCESS;
				end
				RD_ACCESS: begin
					cmd_valid_q <= 1'b1;
					cmd_code_q <= tsa_pkg::TSA_CMD_SERIAL;
					st_q <= RD_RELEASE;
				end
				RD_RELEASE: begin
					// Release deselects (choose with inverted handle) or retires the tag before the next choose
					cmd_valid_q <= 1'b1;
					cmd_code_q <= retire_mode ? tsa_pkg::TSA_CMD_RETIRE : tsa_pkg::TSA_CMD_CHOOSE;
					cmd_arg_q <= ~cmd_arg_q;
					idx_q <= idx_q + 5'h01;
					st_q <= from_open_q ? RD_IDLE : RD_NEXT;
					busy_q <= !from_open_q;
				end
				default: st_q <= RD_IDLE;
			endcase
		end
	end

	assign link.cmd_valid = cmd_valid_q;
	assign link.cmd_code = cmd_code_q;
	assign link.cmd_arg = cmd_arg_q;
	assign link.cmd_frame_ok = 1'b1;
	assign busy = busy_q;
	assign found_valid = found_valid_q;
	assign found_handle = found_q;
endmodule : tsa_reader

// file: sim/tsa_chk.sv
// Assertions on the link that joins the reader end to the tag end.
// Assumes it sits beside that link and sees its signals unchanged.
`timescale 1ns/1ps
module tsa_chk (
	input wire logic mclk,
	input wire logic rst,
	input wire logic cmd_valid,
	input wire tsa_pkg::tsa_cmd_t cmd_code,
	input wire logic [7:0] cmd_arg,
	input wire logic cmd_frame_ok,
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_handle,
	input wire logic exec_valid,
	input wire tsa_pkg::tsa_cmd_t exec_code
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	// Codes below 3 are the anticollision commands, 5 and up the access commands
	wire take = cmd_valid && cmd_frame_ok;
	wire anti = cmd_code < 3'h3;
	a_reply_has_cause: assert property (
		rsp_valid |-> $past(take)) else $error("reply without command");
	a_exec_follows_cmd: assert property (
		exec_valid |-> $past(take) && exec_code == $past(cmd_code)) else $error("exec mismatch");
	a_exec_access_only: assert property (
		exec_valid |-> exec_code >= 3'h5) else $error("exec of non-access command");
	a_access_no_reply: assert property (
		take && !anti |=> !rsp_valid) else $error("reply to non-anticollision command");
	a_anti_no_exec: assert property (
		take && anti |=> !exec_valid) else $error("exec on anticollision command");
	a_marker_nibble: assert property (
		take && cmd_code == tsa_pkg::TSA_CMD_SLOT_MARK ##1 rsp_valid
		|-> rsp_handle[3:0] == $past(cmd_arg[3:0])) else $error("marker reply wrong slot");
	a_start_zero: assert property (
		take && cmd_code == tsa_pkg::TSA_CMD_SLOT_START ##1 rsp_valid
		|-> rsp_handle[3:0] == 4'h0) else $error("slot start reply not slot zero");
	a_reply_one_cycle: assert property (
		rsp_valid |=> !rsp_valid) else $error("reply longer than one cycle");
	c_open_reply: cover property (take && cmd_code == tsa_pkg::TSA_CMD_INV_OPEN ##1 rsp_valid);
	c_slot_start: cover property (take && cmd_code == tsa_pkg::TSA_CMD_SLOT_START);
	c_exec: cover property (exec_valid);
endmodule : tsa_chk

// file: sim/testbench.sv
// Bench: reader and tag joined, plus a second tag driven directly.
// Assumes the package, link and both design ends are compiled first.
`timescale 1ns/1ps
module testbench;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic field_a = 1'b1;
	logic field_b = 1'b1;
	logic start = 1'b0;
	logic collision = 1'b0;
	logic retire_mode = 1'b0;
	logic [7:0] found_handle;
	logic busy;
	tsa_pkg::tsa_state_t st_a;
	tsa_pkg::tsa_state_t st_b;
	logic [7:0] hd_a;
	logic [7:0] hd_b;
	logic [7:0] r;
	logic [7:0] a;
	int m;
	int errors = 0;
	int n_compared = 0;
	// Row: command [7:5], argument [4:3] (0: 8'h01, 1: own handle, 2: inverse), state [2:0]
	logic [7:0] rows [24] = '{
		8'h21, 8'h69, 8'h02, 8'h02, 8'h22, 8'h4A, 8'h52, 8'h42,
		8'hA2, 8'h72, 8'h6B, 8'h03, 8'h23, 8'h4B, 8'hA3, 8'hC3,
		8'hE3, 8'h74, 8'hE4, 8'h74, 8'h6B, 8'h85, 8'h6D, 8'h05
	};
	tsa_link_if lk_a (.mclk(mclk), .rst(rst));
	tsa_link_if lk_b (.mclk(mclk), .rst(rst));
	tsa_reader tsa_reader_i (.link(lk_a), .start(start), .collision(collision),
		.retire_mode(retire_mode), .busy(busy), .found_valid(), .found_handle(found_handle));
	tsa_tag tsa_tag_i (.link(lk_a), .field_ok(field_a), .state(st_a), .handle(hd_a));
	tsa_tag tsa_tag_b_i (.link(lk_b), .field_ok(field_b), .state(st_b), .handle(hd_b));
	tsa_chk tsa_chk_i (.mclk(mclk), .rst(rst), .cmd_valid(lk_a.cmd_valid),
		.cmd_code(lk_a.cmd_code), .cmd_arg(lk_a.cmd_arg), .cmd_frame_ok(lk_a.cmd_frame_ok),
		.rsp_valid(lk_a.rsp_valid), .rsp_handle(lk_a.rsp_handle),
		.exec_valid(lk_a.exec_valid), .exec_code(lk_a.exec_code));
	initial begin
		forever #5 mclk = ~mclk;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wrap_up();
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : wrap_up
	// Handles come from the tag's own generator, so replies are judged by relation
	task automatic cmd(input logic [2:0] c, input logic [7:0] arg, input logic ok);
		logic [2:0] s0;
		logic [7:0] h0;
		logic inv;
		logic rv;
		@(negedge mclk);
		s0 = st_b;
		h0 = hd_b;
		lk_b.cmd_valid = 1'b1;
		lk_b.cmd_code = tsa_pkg::tsa_cmd_t'(c);
		lk_b.cmd_arg = arg;
		lk_b.cmd_frame_ok = ok;
		@(negedge mclk);
		lk_b.cmd_valid = 1'b0;
		inv = ok && s0 == 3'h2;
		rv = inv && (c == 3'h1 ? hd_b[3:0] == 4'h0 : c == 3'h2 && hd_b[3:0] == arg[3:0]);
		if (c == 3'h0)
			rv = ok && (inv || s0 == 3'h1);
		check(lk_b.rsp_valid, rv);
		if (rv)
			check(lk_b.rsp_handle, hd_b);
		check(lk_b.exec_valid, ok && s0 == 3'h3 && c >= 3'h5);
		if (lk_b.exec_valid)
			check(lk_b.exec_code, c);
		if (c == 3'h1 && inv)
			check(hd_b[7:4], h0[7:4]);
		else if (!rv)
			check(hd_b, h0);
	endtask : cmd
	task automatic wait_a(input logic [2:0] s);
		int k;
		for (k = 0; k < 3000 && st_a !== s; k++)
			@(negedge mclk);
		check(st_a, s);
		if (st_a !== s)
			wrap_up();
	endtask : wait_a
	initial begin
		lk_b.cmd_valid = 1'b0;
		lk_b.cmd_code = tsa_pkg::TSA_CMD_INV_OPEN;
		lk_b.cmd_arg = 8'h00;
		lk_b.cmd_frame_ok = 1'b1;
		repeat (2) @(negedge mclk);
		rst = 1'b0;
		foreach (rows[i]) begin
			r = rows[i];
			a = r[4:3] == 2'h1 ? hd_b : (r[4:3] == 2'h2 ? ~hd_b : 8'h01);
			cmd(r[7:5], a, 1'b1);
			check(st_b, r[2:0]);
		end
		$display("state table test done");
		field_b = 1'b0;
		cmd(3'h0, 8'h00, 1'b1);
		check(st_b, 8'h00);
		field_b = 1'b1;
		@(negedge mclk);
		cmd(3'h0, 8'h00, 1'b0);
		check(st_b, 8'h01);
		$display("power and bad frame test done");
		cmd(3'h0, 8'h00, 1'b1);
		repeat (16) cmd(3'h1, 8'h00, 1'b1);
		for (m = 1; m < 16; m++)
			cmd(3'h2, 8'(m), 1'b1);
		check(st_b, 8'h02);
		$display("slot round test done");
		rst = 1'b1;
		@(negedge mclk);
		check(st_b, 8'h00);
		rst = 1'b0;
		@(negedge mclk);
		check(st_b, 8'h01);
		$display("reset test done");
		// Collisions first force slot rounds; the clean reply then ends in release
		collision = 1'b1;
		start = 1'b1;
		@(negedge mclk);
		start = 1'b0;
		repeat (60) @(negedge mclk);
		collision = 1'b0;
		wait_a(3'h4);
		check(found_handle, hd_a);
		retire_mode = 1'b1;
		rst = 1'b1;
		field_a = 1'b0;
		@(negedge mclk);
		rst = 1'b0;
		field_a = 1'b1;
		start = 1'b1;
		@(negedge mclk);
		start = 1'b0;
		wait_a(3'h5);
		check(busy, 8'h00);
		$display("reader pair test done");
		wrap_up();
	end
endmodule : testbench
